/* File: session_role_controller_tb_top.sv */
// Self-checking bench for the session and role controller
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) \
  begin fails++; $display("ERROR %0t %s", $time, msg); end end
module session_role_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import src_pkg::*;

  // Row: request, then grant, command role and data-path role codes
  typedef struct packed {
    src_op_t op;
    logic [6:0] idx;
    logic [2:0] arg;
    logic ok;
    logic [2:0] cmd;
    logic [1:0] dp;
  } src_row_t;

  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic approved = 1'h1;
  logic rd_req = 1'h1;
  logic wr_req = 1'h1;
  logic req_valid, err, resp_valid, resp_ok, purged, rd_en, wr_en, v, ok;
  src_op_t req_op;
  logic [6:0] req_idx;
  src_cmd_role_t req_role, cmd_role;
  src_acc_t req_type;
  src_dp_role_t dp_role;
  logic [7:0] acc_count;
  int fails = 0;
  int total_checks = 0;

  // Roles: 0 none 1 initiator 2 officer 3 manager 4 user
  // Data-path: 0 none 1 drive 2 migrate 3 update
  src_row_t rows [31] = '{
    '{SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h0, 3'h0, 2'h0},
    '{SRC_OP_AUTO_AUTH, 7'h0, 3'h0, 1'h0, 3'h0, 2'h0},
    '{SRC_OP_LOGIN_INIT, 7'h0, 3'h0, 1'h1, 3'h1, 2'h0},
    '{SRC_OP_BOOT, 7'h0, 3'h0, 1'h0, 3'h1, 2'h0},
    '{SRC_OP_CREATE, 7'h0, 3'h2, 1'h0, 3'h1, 2'h0},
    '{SRC_OP_INIT_CORE, 7'h0, 3'h0, 1'h1, 3'h1, 2'h0},
    '{SRC_OP_CREATE, 7'h0, 3'h3, 1'h0, 3'h1, 2'h0},
    '{SRC_OP_CREATE, 7'h0, 3'h2, 1'h1, 3'h1, 2'h0},
    '{SRC_OP_CREATE, 7'h1, 3'h2, 1'h0, 3'h1, 2'h0},
    '{SRC_OP_LOGOUT_CMD, 7'h0, 3'h0, 1'h1, 3'h0, 2'h0},
    '{SRC_OP_LOGIN_INIT, 7'h0, 3'h0, 1'h0, 3'h0, 2'h0},
    '{SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h1, 3'h2, 2'h0},
    '{SRC_OP_CREATE, 7'h1, 3'h4, 1'h1, 3'h2, 2'h0},
    '{SRC_OP_CREATE, 7'h2, 3'h3, 1'h1, 3'h2, 2'h0},
    '{SRC_OP_LOGIN_OP, 7'h0, 3'h3, 1'h0, 3'h2, 2'h0},
    '{SRC_OP_MIGRATE, 7'h0, 3'h0, 1'h1, 3'h2, 2'h2},
    '{SRC_OP_UNLOCK, 7'h0, 3'h0, 1'h0, 3'h2, 2'h2},
    '{SRC_OP_LOGIN_OP, 7'h1, 3'h4, 1'h0, 3'h2, 2'h2},
    '{SRC_OP_LOGOUT_DP, 7'h0, 3'h0, 1'h1, 3'h2, 2'h0},
    '{SRC_OP_UNLOCK, 7'h0, 3'h0, 1'h1, 3'h2, 2'h3},
    '{SRC_OP_LOGOUT_DP, 7'h0, 3'h0, 1'h1, 3'h2, 2'h0},
    '{SRC_OP_BOOT_KEEP, 7'h0, 3'h0, 1'h1, 3'h2, 2'h1},
    '{SRC_OP_LOGOUT_CMD, 7'h0, 3'h0, 1'h1, 3'h0, 2'h1},
    '{SRC_OP_LOGIN_OP, 7'h1, 3'h2, 1'h0, 3'h0, 2'h1},
    '{SRC_OP_LOGIN_OP, 7'h1, 3'h4, 1'h1, 3'h4, 2'h1},
    '{SRC_OP_LOGOUT_DP, 7'h0, 3'h0, 1'h1, 3'h4, 2'h0},
    '{SRC_OP_MIGRATE, 7'h0, 3'h0, 1'h0, 3'h4, 2'h0},
    '{SRC_OP_BOOT, 7'h0, 3'h0, 1'h1, 3'h0, 2'h1},
    '{SRC_OP_LOGIN_OP, 7'h2, 3'h2, 1'h0, 3'h0, 2'h1},
    '{SRC_OP_LOGIN_OP, 7'h2, 3'h3, 1'h1, 3'h3, 2'h1},
    '{SRC_OP_LOGOUT_CMD, 7'h0, 3'h0, 1'h1, 3'h0, 2'h1}
  };

  src_session_ctrl i_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_req_valid(req_valid),
    .i_req_op(req_op), .i_req_acc_idx(req_idx), .i_req_role(req_role),
    .i_req_acc_type(req_type), .i_error_event(err),
    .i_approved_mode(approved), .i_preauth_wr_req(wr_req),
    .i_preauth_rd_req(rd_req), .o_resp_valid(resp_valid),
    .o_resp_ok(resp_ok), .o_cmd_role(cmd_role), .o_dp_role(dp_role),
    .o_cmd_acc_idx(), .o_acc_count(acc_count), .o_purged(purged),
    .o_core_initialized(), .o_preauth_rd_en(rd_en), .o_preauth_wr_en(wr_en)
  );

  src_host_model i_host (
    .i_clk_sys(clk), .i_resp_valid(resp_valid), .i_resp_ok(resp_ok),
    .o_req_valid(req_valid), .o_req_op(req_op), .o_req_acc_idx(req_idx),
    .o_req_role(req_role), .o_req_acc_type(req_type), .o_error_event(err)
  );

  // 25 MHz system clock
  initial begin
    forever #20 clk = ~clk;
  end

  // One request and its expected outcome
  task automatic step(input src_row_t r);
    i_host.req(r.op, r.idx, r.arg, 1'h0, v, ok);
    `CHK(v, 1'h1, "no response")
    `CHK(ok, r.ok, "grant differs")
    `CHK(cmd_role, r.cmd, "command role differs")
    `CHK(dp_role, r.dp, "data-path role differs")
  endtask : step

  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Table first, then the awkward cases
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[k]) step(rows[k]);
    step('{SRC_OP_LOGOUT_DP, 7'h0, 3'h0, 1'h1, 3'h0, 2'h0});
    `CHK({rd_en, wr_en}, 2'h2, "region access in no-role")
    @(posedge clk);
    approved <= 1'h0;
    step('{SRC_OP_AUTO_AUTH, 7'h0, 3'h0, 1'h1, 3'h0, 2'h1});
    step('{SRC_OP_LOGOUT_DP, 7'h0, 3'h0, 1'h1, 3'h0, 2'h0});
    step('{SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h1, 3'h2, 2'h0});
    // Fill every remaining slot up to the limit
    for (int i = 3; i < 128; i++) begin
      i_host.req(SRC_OP_CREATE, 7'(i), 3'h4, 1'h0, v, ok);
    end
    `CHK(acc_count, 8'h80, "account count at limit")
    step('{SRC_OP_CREATE, 7'h7F, 3'h4, 1'h0, 3'h2, 2'h0});
    `CHK(acc_count, 8'h80, "account count past limit")
    step('{SRC_OP_BOOT_KEEP, 7'h0, 3'h0, 1'h1, 3'h2, 2'h1});
    i_host.req(SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h1, v, ok);
    `CHK({ok, cmd_role, dp_role}, 6'h0, "error event kept roles")
    step('{SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h1, 3'h2, 2'h0});
    step('{SRC_OP_RESTART, 7'h0, 3'h0, 1'h1, 3'h0, 2'h0});
    step('{SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h1, 3'h2, 2'h0});
    step('{SRC_OP_PURGE, 7'h0, 3'h0, 1'h1, 3'h0, 2'h0});
    step('{SRC_OP_LOGIN_OP, 7'h0, 3'h2, 1'h0, 3'h0, 2'h0});
    `CHK(purged, 1'h1, "purge flag not set")
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    `CHK({cmd_role, dp_role, acc_count}, 13'h0, "reset state")
    step('{SRC_OP_LOGIN_INIT, 7'h0, 3'h0, 1'h1, 3'h1, 2'h0});
    end_of_test();
  end
endmodule : session_role_controller_tb_top

/* File: src_acc_if.sv */
// Interface carrying account table lookups and updates
interface src_acc_if #(parameter int IDX_W = 7, parameter int CNT_W = 8);
  import src_pkg::*;
  logic [IDX_W-1:0] idx;
  src_acc_t rd_type;
  logic [CNT_W-1:0] count;
  logic init_officer_exists;
  logic wr_en;
  src_acc_t wr_type;
  logic clear_all;
  modport table_side (input idx, wr_en, wr_type, clear_all,
    output rd_type, count, init_officer_exists);
  modport ctrl_side (output idx, wr_en, wr_type, clear_all,
    input rd_type, count, init_officer_exists);
endinterface : src_acc_if

/* File: src_acc_table.sv */
// Account type storage with count of live operator accounts
module src_acc_table #(
  parameter int DEPTH = src_pkg::SRC_MAX_ACCOUNTS
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Table port
  src_acc_if.table_side acc
);
  import src_pkg::*;

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << SRC_IDX_W))
      $error("src_acc_table: DEPTH out of range");
  end

  src_acc_t type_reg [DEPTH];
  logic [SRC_CNT_W-1:0] count_reg;
  logic init_off_reg;

  wire logic old_live = (acc.rd_type != SRC_ACC_EMPTY);
  wire logic new_live = (acc.wr_type != SRC_ACC_EMPTY);
  wire logic was_init = (acc.rd_type == SRC_ACC_INIT_OFFICER);
  wire logic becomes_init = (acc.wr_type == SRC_ACC_INIT_OFFICER);

  // Read is combinational so the controller checks type in the same cycle
  assign acc.rd_type = type_reg[acc.idx];
  assign acc.count = count_reg;
  assign acc.init_officer_exists = init_off_reg;

  // Slot storage
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) type_reg[i] <= SRC_ACC_EMPTY;
    end else if (acc.clear_all) begin
      for (int i = 0; i < DEPTH; i++) type_reg[i] <= SRC_ACC_EMPTY;
    end else if (acc.wr_en) begin
      type_reg[acc.idx] <= acc.wr_type;
    end
  end

  // Live count and initial officer flag follow every write
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= SRC_CNT_RESET;
      init_off_reg <= 1'b0;
    end else if (acc.clear_all) begin
      count_reg <= SRC_CNT_RESET;
      init_off_reg <= 1'b0;
    end else if (acc.wr_en) begin
      if (new_live && !old_live) count_reg <= count_reg + 8'h01;
      else if (!new_live && old_live) count_reg <= count_reg - 8'h01;
      if (becomes_init) init_off_reg <= 1'b1;
      else if (was_init) init_off_reg <= 1'b0;
    end
  end
endmodule : src_acc_table

/* File: src_host_model.sv */
// Host model issuing one service request at a time
module src_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Answer from the controller
  input wire logic i_resp_valid,
  input wire logic i_resp_ok,
  // Request towards the controller
  output logic o_req_valid,
  output src_pkg::src_op_t o_req_op,
  output logic [6:0] o_req_acc_idx,
  output src_pkg::src_cmd_role_t o_req_role,
  output src_pkg::src_acc_t o_req_acc_type,
  output logic o_error_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import src_pkg::*;

  // Idle bus at time zero
  initial begin
    o_req_valid = 1'h0;
    o_req_op = SRC_OP_NOP;
    o_req_acc_idx = 7'h0;
    o_req_role = SRC_CMD_NONE;
    o_req_acc_type = SRC_ACC_EMPTY;
    o_error_event = 1'h0;
  end

  // Raise after an edge, hold over the taking edge, sample the answer
  task automatic req(input src_op_t op, input logic [6:0] idx,
      input logic [2:0] arg, input logic err, output logic got_v,
      output logic got_ok);
    @(posedge i_clk_sys);
    o_req_valid <= 1'h1;
    o_req_op <= op;
    o_req_acc_idx <= idx;
    o_req_role <= src_cmd_role_t'(arg);
    o_req_acc_type <= src_acc_t'(arg);
    o_error_event <= err;
    @(posedge i_clk_sys);
    o_req_valid <= 1'h0;
    o_error_event <= 1'h0;
    // Released slot field does not keep its last value
    o_req_acc_idx <= ~idx;
    #1;
    got_v = i_resp_valid;
    got_ok = i_resp_ok;
  endtask : req
endmodule : src_host_model

/* File: src_login_check.sv */
// Pure decision logic for logins and data-path transitions
module src_login_check (
  // Present state
  input wire src_pkg::src_cmd_role_t i_cmd_role,
  input wire src_pkg::src_dp_role_t i_dp_role,
  input wire logic i_purged,
  input wire logic i_approved_mode,
  input wire logic i_initiator_ready,
  // Request
  input wire src_pkg::src_op_t i_op,
  input wire src_pkg::src_cmd_role_t i_want_role,
  input wire src_pkg::src_acc_t i_acc_type,
  input wire logic i_acc_idx_ok,
  input wire logic [7:0] i_acc_count,
  // Decision
  output logic o_login_ok,
  output logic o_dp_ok
);
  import src_pkg::*;

  // Role allowed by account type, role chosen at login
  function automatic logic type_allows(src_acc_t t, src_cmd_role_t r);
    case (t)
      SRC_ACC_OFFICER, SRC_ACC_INIT_OFFICER:
        type_allows = (r == SRC_CMD_OFFICER) || (r == SRC_CMD_MANAGER) ||
                      (r == SRC_CMD_USER);
      SRC_ACC_MANAGER:
        type_allows = (r == SRC_CMD_MANAGER) || (r == SRC_CMD_USER);
      SRC_ACC_USER: type_allows = (r == SRC_CMD_USER);
      default: type_allows = 1'b0;
    endcase
  endfunction : type_allows

  wire logic no_ops = (i_acc_count == 8'h00);
  wire logic cmd_free = (i_cmd_role == SRC_CMD_NONE);
  wire logic dp_free = (i_dp_role == SRC_DP_NONE);
  wire logic cmd_not_init = !cmd_free && (i_cmd_role != SRC_CMD_INITIATOR);
  wire logic is_officer = (i_cmd_role == SRC_CMD_OFFICER);
  // Both sides held blocks every login; a free command side is needed
  wire logic login_slot = cmd_free && !i_purged;
  wire logic init_ok = login_slot && no_ops && dp_free &&
                       i_initiator_ready;
  wire logic op_ok = login_slot && !no_ops && i_acc_idx_ok &&
                     type_allows(i_acc_type, i_want_role);
  wire logic boot_ok = dp_free && cmd_not_init && !i_purged;
  wire logic off_ok = dp_free && is_officer && !i_purged;
  wire logic auto_ok = dp_free && cmd_free && !i_purged &&
                       !i_approved_mode;

  assign o_login_ok = (i_op == SRC_OP_LOGIN_INIT) ? init_ok :
                      (i_op == SRC_OP_LOGIN_OP) ? op_ok : 1'b0;
  assign o_dp_ok = (i_op == SRC_OP_BOOT || i_op == SRC_OP_BOOT_KEEP) ?
                   boot_ok :
                   (i_op == SRC_OP_MIGRATE || i_op == SRC_OP_UNLOCK) ?
                   off_ok :
                   (i_op == SRC_OP_AUTO_AUTH) ? auto_ok : 1'b0;
endmodule : src_login_check

/* File: src_pkg.sv */
// Package of roles, account types, commands and limits for the session core
// Notes on behaviour
// - Power-up or restart puts both sides no-role
// - No operator accounts: only initiator login accepted
// - Initiator may init, create officer; no data-path
// - Operator login needs at least one account
// - Operator logout; boot moves session to data-path
// - Boot variant keeps command session, adds data-path
// - Officer only: migrate or unlock, session kept
// - Command side free, data-path held: operator login allowed
// - Both sides held: refuse all logins
// - Logout service or error clears command side
// - Logout service or error clears data-path side
// - Data-path no-role: preauth region read only
// - Auto authentication disabled in approved mode
// - Up to 128 operator accounts, excess rejected
// - Account type limits command-side roles
// - One initiator account, only with zero operators
// - Role chosen at login; change needs relogin
// - Initiator creates only one initial officer account
// - User account may take only user role
// - One dedicated auto-authentication account
// - After purge every role is refused
// - Migrate, update from officer; drive access not initiator
// - A side returns to no-role before role change
package src_pkg;
  // Command-handling side roles
  typedef enum logic [2:0] {
    SRC_CMD_NONE,
    SRC_CMD_INITIATOR,
    SRC_CMD_OFFICER,
    SRC_CMD_MANAGER,
    SRC_CMD_USER
  } src_cmd_role_t;

  // Data-path side roles
  typedef enum logic [1:0] {
    SRC_DP_NONE,
    SRC_DP_DRIVE_ACCESS,
    SRC_DP_KEY_MIGRATE,
    SRC_DP_PREAUTH_UPDATE
  } src_dp_role_t;

  // Account types stored per operator slot
  typedef enum logic [2:0] {
    SRC_ACC_EMPTY,
    SRC_ACC_OFFICER,
    SRC_ACC_INIT_OFFICER,
    SRC_ACC_MANAGER,
    SRC_ACC_USER
  } src_acc_t;

  // Host service requests
  typedef enum logic [3:0] {
    SRC_OP_NOP,
    SRC_OP_LOGIN_INIT,
    SRC_OP_LOGIN_OP,
    SRC_OP_LOGOUT_CMD,
    SRC_OP_LOGOUT_DP,
    SRC_OP_BOOT,
    SRC_OP_BOOT_KEEP,
    SRC_OP_MIGRATE,
    SRC_OP_UNLOCK,
    SRC_OP_CREATE,
    SRC_OP_DELETE,
    SRC_OP_RESTART,
    SRC_OP_PURGE,
    SRC_OP_INIT_CORE,
    SRC_OP_AUTO_AUTH
  } src_op_t;

  localparam int SRC_MAX_ACCOUNTS = 128;
  localparam int SRC_IDX_W = 7;
  localparam int SRC_CNT_W = 8;
  localparam logic [7:0] SRC_CNT_RESET = 8'h00;
endpackage : src_pkg

/* File: src_session_ctrl.sv */
// Top-level session and role controller
module src_session_ctrl (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Host request
  input wire logic i_req_valid,
  input wire src_pkg::src_op_t i_req_op,
  input wire logic [6:0] i_req_acc_idx,
  input wire src_pkg::src_cmd_role_t i_req_role,
  input wire src_pkg::src_acc_t i_req_acc_type,
  // Events and mode
  input wire logic i_error_event,
  input wire logic i_approved_mode,
  // Drive region access request
  input wire logic i_preauth_wr_req,
  input wire logic i_preauth_rd_req,
  // Answer
  output logic o_resp_valid,
  output logic o_resp_ok,
  // Role state
  output src_pkg::src_cmd_role_t o_cmd_role,
  output src_pkg::src_dp_role_t o_dp_role,
  output logic [6:0] o_cmd_acc_idx,
  output logic [7:0] o_acc_count,
  output logic o_purged,
  output logic o_core_initialized,
  // Region permissions
  output logic o_preauth_rd_en,
  output logic o_preauth_wr_en
);
  import src_pkg::*;

  src_acc_if #(.IDX_W(SRC_IDX_W), .CNT_W(SRC_CNT_W)) acc ();

  src_cmd_role_t cmd_role_reg, cmd_role_next;
  src_dp_role_t dp_role_reg, dp_role_next;
  logic [6:0] cmd_idx_reg, cmd_idx_next;
  logic purged_reg, purged_next;
  logic init_done_reg, init_done_next;
  logic resp_valid_reg, resp_ok_reg, ok_next;
  logic login_ok, dp_ok;

  // Account table
  src_acc_table #(.DEPTH(SRC_MAX_ACCOUNTS)) u_table (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .acc(acc)
  );

  // Decision logic
  src_login_check u_check (
    .i_cmd_role(cmd_role_reg),
    .i_dp_role(dp_role_reg),
    .i_purged(purged_reg),
    .i_approved_mode(i_approved_mode),
    .i_initiator_ready(1'b1),
    .i_op(i_req_op),
    .i_want_role(i_req_role),
    .i_acc_type(acc.rd_type),
    .i_acc_idx_ok(1'b1),
    .i_acc_count(acc.count),
    .o_login_ok(login_ok),
    .o_dp_ok(dp_ok)
  );

  // Request decode
  wire logic req = i_req_valid && !i_error_event;
  wire logic op_login = (i_req_op == SRC_OP_LOGIN_INIT) ||
                        (i_req_op == SRC_OP_LOGIN_OP);
  wire logic op_dp = (i_req_op == SRC_OP_BOOT) ||
                     (i_req_op == SRC_OP_BOOT_KEEP) ||
                     (i_req_op == SRC_OP_MIGRATE) ||
                     (i_req_op == SRC_OP_UNLOCK) ||
                     (i_req_op == SRC_OP_AUTO_AUTH);
  wire logic is_initiator = (cmd_role_reg == SRC_CMD_INITIATOR);
  wire logic can_manage = (cmd_role_reg == SRC_CMD_OFFICER) ||
                          (cmd_role_reg == SRC_CMD_MANAGER);
  wire logic slot_empty = (acc.rd_type == SRC_ACC_EMPTY);
  wire logic table_full = (acc.count == 8'(SRC_MAX_ACCOUNTS));
  // Initiator may only add the single initial officer account
  wire logic init_create_ok = is_initiator && init_done_reg &&
    (i_req_acc_type == SRC_ACC_INIT_OFFICER) &&
    !acc.init_officer_exists;
  // Officer and manager add ordinary accounts; manager never adds officers
  wire logic op_create_ok = can_manage &&
    (i_req_acc_type != SRC_ACC_INIT_OFFICER) &&
    (i_req_acc_type != SRC_ACC_EMPTY) &&
    ((cmd_role_reg == SRC_CMD_OFFICER) ||
     (i_req_acc_type != SRC_ACC_OFFICER));
  wire logic create_ok = (i_req_op == SRC_OP_CREATE) && req &&
    !purged_reg && slot_empty && !table_full &&
    (init_create_ok || op_create_ok);
  wire logic delete_ok = (i_req_op == SRC_OP_DELETE) && req &&
    (cmd_role_reg == SRC_CMD_OFFICER) && !slot_empty &&
    (i_req_acc_idx != cmd_idx_reg);
  wire logic init_core_ok = (i_req_op == SRC_OP_INIT_CORE) && req &&
    is_initiator;
  wire logic role_from_acc = (i_req_op == SRC_OP_LOGIN_OP);

  // Data-path role that a granted transition enters
  function automatic src_dp_role_t dp_target(src_op_t op);
    case (op)
      SRC_OP_MIGRATE: dp_target = SRC_DP_KEY_MIGRATE;
      SRC_OP_UNLOCK: dp_target = SRC_DP_PREAUTH_UPDATE;
      default: dp_target = SRC_DP_DRIVE_ACCESS;
    endcase
  endfunction : dp_target

  // Table access
  assign acc.idx = i_req_acc_idx;
  assign acc.wr_en = create_ok || delete_ok;
  assign acc.wr_type = delete_ok ? SRC_ACC_EMPTY : i_req_acc_type;
  assign acc.clear_all = 1'b0;

  // Next state of both sides
  always_comb begin
    cmd_role_next = cmd_role_reg;
    dp_role_next = dp_role_reg;
    cmd_idx_next = cmd_idx_reg;
    purged_next = purged_reg;
    init_done_next = init_done_reg;
    ok_next = 1'b0;
    if (i_error_event) begin
      cmd_role_next = SRC_CMD_NONE;
      dp_role_next = SRC_DP_NONE;
    end else if (req) begin
      case (i_req_op)
        SRC_OP_LOGIN_INIT, SRC_OP_LOGIN_OP: begin
          if (login_ok) begin
            cmd_role_next = role_from_acc ? i_req_role : SRC_CMD_INITIATOR;
            cmd_idx_next = i_req_acc_idx;
            ok_next = 1'b1;
          end
        end
        SRC_OP_LOGOUT_CMD: begin
          ok_next = (cmd_role_reg != SRC_CMD_NONE);
          cmd_role_next = SRC_CMD_NONE;
        end
        SRC_OP_LOGOUT_DP: begin
          ok_next = (dp_role_reg != SRC_DP_NONE);
          dp_role_next = SRC_DP_NONE;
        end
        SRC_OP_BOOT, SRC_OP_BOOT_KEEP, SRC_OP_MIGRATE, SRC_OP_UNLOCK,
        SRC_OP_AUTO_AUTH: begin
          if (dp_ok) begin
            dp_role_next = dp_target(i_req_op);
            if (i_req_op == SRC_OP_BOOT)
              cmd_role_next = SRC_CMD_NONE;
            ok_next = 1'b1;
          end
        end
        SRC_OP_CREATE, SRC_OP_DELETE: begin
          ok_next = create_ok || delete_ok;
        end
        SRC_OP_INIT_CORE: begin
          if (init_core_ok) init_done_next = 1'b1;
          ok_next = init_core_ok;
        end
        SRC_OP_PURGE: begin
          if (can_manage) begin
            purged_next = 1'b1;
            cmd_role_next = SRC_CMD_NONE;
            dp_role_next = SRC_DP_NONE;
            ok_next = 1'b1;
          end
        end
        SRC_OP_RESTART: begin
          cmd_role_next = SRC_CMD_NONE;
          dp_role_next = SRC_DP_NONE;
          ok_next = 1'b1;
        end
        default: ok_next = 1'b0;
      endcase
    end
  end

  // Role state, reset leaves both sides with no role
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_role_reg <= SRC_CMD_NONE;
      dp_role_reg <= SRC_DP_NONE;
      cmd_idx_reg <= 7'h00;
    end else begin
      cmd_role_reg <= cmd_role_next;
      dp_role_reg <= dp_role_next;
      cmd_idx_reg <= cmd_idx_next;
    end
  end

  // Core flags; purge is held until reset since parameters are gone
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      purged_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else begin
      purged_reg <= purged_next;
      init_done_reg <= init_done_next;
    end
  end

  // Answer, one cycle after the request; a refusal changes nothing except that an error event clears both sides
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resp_valid_reg <= 1'b0;
      resp_ok_reg <= 1'b0;
    end else begin
      resp_valid_reg <= i_req_valid;
      resp_ok_reg <= ok_next;
    end
  end

  assign o_resp_valid = resp_valid_reg;
  assign o_resp_ok = resp_ok_reg;
  assign o_cmd_role = cmd_role_reg;
  assign o_dp_role = dp_role_reg;
  assign o_cmd_acc_idx = cmd_idx_reg;
  assign o_acc_count = acc.count;
  assign o_purged = purged_reg;
  assign o_core_initialized = init_done_reg;

  // Preauth region: read with no data-path role or update role, write via update role
  assign o_preauth_rd_en = i_preauth_rd_req && !purged_reg &&
    ((dp_role_reg == SRC_DP_NONE) ||
     (dp_role_reg == SRC_DP_PREAUTH_UPDATE));
  assign o_preauth_wr_en = i_preauth_wr_req &&
    (dp_role_reg == SRC_DP_PREAUTH_UPDATE);
endmodule : src_session_ctrl

/* File: src_session_ctrl_sva.sv */
// Concurrent checks on the session controller ports
module src_session_ctrl_sva (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Requests, events and region requests
  input wire logic i_req_valid,
  input wire src_pkg::src_op_t i_req_op,
  input wire logic i_error_event,
  input wire logic i_approved_mode,
  input wire logic i_preauth_wr_req,
  input wire logic i_preauth_rd_req,
  // Outputs watched
  input wire logic o_resp_valid,
  input wire logic o_resp_ok,
  input wire src_pkg::src_cmd_role_t o_cmd_role,
  input wire src_pkg::src_dp_role_t o_dp_role,
  input wire logic [7:0] o_acc_count,
  input wire logic o_purged,
  input wire logic o_preauth_rd_en,
  input wire logic o_preauth_wr_en
);
  import src_pkg::*;
  // One clock domain, so clocking and reset are stated once
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  resp_follows_a: assert property (i_req_valid |=> o_resp_valid)
    else $error("no response after request");
  resp_only_a: assert property (!i_req_valid |=> !o_resp_valid)
    else $error("response without request");
  error_clears_a: assert property (i_error_event |=>
    o_cmd_role == SRC_CMD_NONE && o_dp_role == SRC_DP_NONE)
    else $error("error event left a role");
  error_refuse_a: assert property (i_req_valid && i_error_event |=>
    o_resp_valid && !o_resp_ok)
    else $error("request granted during error event");
  refuse_keeps_a: assert property (o_resp_valid && !o_resp_ok &&
    !$past(i_error_event) |-> $stable(o_cmd_role) && $stable(o_dp_role))
    else $error("refused request changed a role");
  init_no_dp_a: assert property (o_cmd_role == SRC_CMD_INITIATOR |->
    o_dp_role == SRC_DP_NONE)
    else $error("initiator holds a data-path role");
  dp_via_none_a: assert property ($changed(o_dp_role) &&
    $past(o_dp_role) != SRC_DP_NONE |-> o_dp_role == SRC_DP_NONE)
    else $error("data-path role changed without no-role");
  preauth_wr_a: assert property (o_preauth_wr_en |->
    i_preauth_wr_req && o_dp_role == SRC_DP_PREAUTH_UPDATE)
    else $error("region write enabled outside update role");
  preauth_rd_a: assert property (i_preauth_rd_req && !o_purged &&
    o_dp_role == SRC_DP_NONE |-> o_preauth_rd_en)
    else $error("region read refused in no-role");
  purge_block_a: assert property (o_purged && i_req_valid &&
    i_req_op inside {SRC_OP_LOGIN_INIT, SRC_OP_LOGIN_OP} |=> !o_resp_ok)
    else $error("login granted after purge");
  auto_off_a: assert property (i_approved_mode && i_req_valid &&
    i_req_op == SRC_OP_AUTO_AUTH |=> !o_resp_ok)
    else $error("auto authentication in approved mode");
  count_cap_a: assert property (o_acc_count <= 8'h80)
    else $error("account count above limit");
endmodule : src_session_ctrl_sva

bind src_session_ctrl src_session_ctrl_sva i_sva (
  .i_clk_sys, .i_rst_n, .i_req_valid, .i_req_op, .i_error_event,
  .i_approved_mode, .i_preauth_wr_req, .i_preauth_rd_req, .o_resp_valid,
  .o_resp_ok, .o_cmd_role, .o_dp_role, .o_acc_count, .o_purged,
  .o_preauth_rd_en, .o_preauth_wr_en
);
